// ### shared/dpram_host_pkg.sv
// Constants for the dual-port RAM port controller
package dpram_host_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam logic [9:0] MAILBOX_RIGHT = 10'h3FF;
	localparam logic [9:0] MAILBOX_LEFT = 10'h3FE;
	localparam int CLK_PERIOD_NS = 10;
	// Timing figures in ns
	localparam int WRITE_TURNOFF_DELAY_NS = 13;
	localparam int WRITE_DATA_SETUP_NS = 13;
	localparam int MIN_WRITE_PULSE_WIDTH_NS = 15;
	localparam int BUSY_FROM_MATCH_DELAY_NS = 20;
	localparam int READ_ACCESS_NS = 20;
	localparam int PULSE_NS = (MIN_WRITE_PULSE_WIDTH_NS > WRITE_TURNOFF_DELAY_NS +
		WRITE_DATA_SETUP_NS) ? MIN_WRITE_PULSE_WIDTH_NS :
		WRITE_TURNOFF_DELAY_NS + WRITE_DATA_SETUP_NS;
	// Least times round up to cycles
	localparam int WRITE_PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXTEND_CYC = (MIN_WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MATCH_CYC = (BUSY_FROM_MATCH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Depth of the read data synchroniser
	localparam int SYNC_CYC = 2;
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_WAIT_BUSY,
		ST_EXTEND,
		ST_DONE
	} state_type;
endpackage

// ### rtl/dpram_port_host.sv
// Controller driving one port of the arbitrated dual-port RAM
// Overview of operation
// RQ1: During reads the write strobe stays high throughout.
// RQ2: Address is driven before or with chip select falling.
// RQ3: Device keeps data outputs off when select falls with or after strobe.
// RQ4: Strobe with output enable low lasts turn-off plus setup, or minimum width.
// RQ5: Device writes only while select and strobe are both low.
// RQ6: Device holds 1024 bytes reachable from both ports.
// RQ7: 3FF is the right mailbox, 3FE the left mailbox.
// RQ8: Writing the opposite mailbox asserts the owner's interrupt.
// RQ9: Owner reading its mailbox clears its interrupt.
// RQ10: Contention only when same address and both selects active.
// RQ11: First arriving port wins; leading by setup interval guarantees it.
// RQ12: Near-simultaneous requests still give exactly one winner.
// RQ13: Loser gets busy; only the master drives busy.
// RQ14: Both reads proceed with valid data; loser still sees busy.
// RQ15: Winner reads valid data; loser's write is blocked.
// RQ16: Winner's write completes; loser's read data may be mixed.
// RQ17: Both writing: winner completes, loser's write is blocked.
// RQ18: On busy, wait for release then extend the operation one more cycle; code extends writes 2 cycles, reads 4.
// RQ19: Written data flows through to a reader of the same address.
// RQ20: Loser holding strobe a minimum width after busy release writes successfully.
// RQ21: Only one master with any number of slaves in parallel.
// RQ22: Slave write strobes delayed by at least the busy-from-match delay.
// RQ23: Slave busy pins are inputs from the master's busy outputs.
// RQ24: Busy and interrupt are active low and held until cleared.
`timescale 1ns/100ps
`default_nettype none
module dpram_port_host
	import dpram_host_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// User request side
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [DATA_W-1:0] rsp_rdata_o,
	output logic rsp_busy_seen_o,
	output logic mail_pending_o,
	// RAM port pins
	output logic [ADDR_W-1:0] ram_addr_o,
	output logic ram_select_n_o,
	output logic ram_write_n_o,
	output logic ram_output_en_n_o,
	input wire logic [DATA_W-1:0] ram_data_i,
	output logic [DATA_W-1:0] ram_data_o,
	output logic ram_data_oe_n_o,
	input wire logic ram_busy_n_i,
	input wire logic ram_int_n_i
);
	state_type state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic write_reg, write_next;
	logic busy_seen_reg, busy_seen_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic [DATA_W-1:0] din_meta_reg, din_sync_reg;
	logic busy_meta_reg, busy_sync_reg;
	logic int_meta_reg, int_sync_reg;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = n[CNT_W-1:0];
	endfunction

	// Read strobe covers the access time and the data synchroniser
	function automatic logic [CNT_W-1:0] read_count();
		read_count = cyc(READ_CYC) + cyc(SYNC_CYC);
	endfunction

	// Phase counter helpers
	function automatic logic count_running(input logic [CNT_W-1:0] c);
		count_running = c > CNT_ONE;
	endfunction

	function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
		count_down = c - CNT_ONE;
	endfunction

	function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c);
		count_up = c + CNT_ONE;
	endfunction

	// Pin synchronisers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			din_meta_reg <= 8'h00;
			din_sync_reg <= 8'h00;
			busy_meta_reg <= 1'b1;
			busy_sync_reg <= 1'b1;
			int_meta_reg <= 1'b1;
			int_sync_reg <= 1'b1;
		end else begin
			din_meta_reg <= ram_data_i;
			din_sync_reg <= din_meta_reg;
			busy_meta_reg <= ram_busy_n_i; // RQ23
			busy_sync_reg <= busy_meta_reg;
			int_meta_reg <= ram_int_n_i;
			int_sync_reg <= int_meta_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		write_next = write_reg;
		busy_seen_next = busy_seen_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		rsp_valid_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_i) begin
					addr_next = req_addr_i;
					wdata_next = req_wdata_i;
					write_next = req_write_i;
					busy_seen_next = 1'b0;
					state_next = ST_SETUP;
				end
			end
			// Address settles with select low; write waits out the match delay
			ST_SETUP: begin
				if (!write_reg) begin
					cnt_next = read_count(); // RQ2
					state_next = ST_STROBE;
				end else if (count_up(cnt_reg) >= cyc(MATCH_CYC)) begin // RQ22
					cnt_next = cyc(WRITE_PULSE_CYC); // RQ4
					state_next = ST_STROBE;
				end else begin
					cnt_next = count_up(cnt_reg);
				end
			end
			ST_STROBE: begin
				if (!busy_sync_reg) begin
					busy_seen_next = 1'b1; // RQ13
				end
				if (count_running(cnt_reg)) begin
					cnt_next = count_down(cnt_reg);
				end else if (!busy_sync_reg || busy_seen_reg) begin
					state_next = ST_WAIT_BUSY; // RQ18
				end else begin
					rdata_next = din_sync_reg;
					state_next = ST_DONE;
				end
			end
			ST_WAIT_BUSY: begin
				if (busy_sync_reg) begin
					cnt_next = write_reg ? cyc(EXTEND_CYC) : read_count(); // RQ20
					state_next = ST_EXTEND;
				end
			end
			ST_EXTEND: begin
				if (!busy_sync_reg) begin
					state_next = ST_WAIT_BUSY;
				end else if (count_running(cnt_reg)) begin
					cnt_next = count_down(cnt_reg);
				end else begin
					rdata_next = din_sync_reg; // RQ18
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				rsp_valid_next = 1'b1;
				cnt_next = CNT_ZERO;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= CNT_ZERO;
			write_reg <= 1'b0;
			busy_seen_reg <= 1'b0;
			addr_reg <= 10'h000;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
			rsp_valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			write_reg <= write_next;
			busy_seen_reg <= busy_seen_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			rsp_valid_reg <= rsp_valid_next;
		end
	end

	// Phase decode of the state
	logic active;
	logic strobing;
	logic read_op;
	logic write_op;
	assign active = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
	assign strobing = (state_reg == ST_STROBE) || (state_reg == ST_WAIT_BUSY) ||
		(state_reg == ST_EXTEND);
	assign read_op = active && !write_reg;
	assign write_op = active && write_reg;

	// Status toward the user
	assign req_ready_o = (state_reg == ST_IDLE);
	assign rsp_valid_o = rsp_valid_reg;
	assign rsp_rdata_o = rdata_reg;
	assign rsp_busy_seen_o = busy_seen_reg;
	assign mail_pending_o = !int_sync_reg; // RQ24

	// Pin drive toward the RAM
	assign ram_addr_o = addr_reg;
	assign ram_select_n_o = !active; // RQ2
	assign ram_write_n_o = !(write_reg && strobing); // RQ1
	assign ram_output_en_n_o = !read_op;
	assign ram_data_o = wdata_reg;
	assign ram_data_oe_n_o = !write_op; // RQ4
endmodule // dpram_port_host
`default_nettype wire

// ### verification/dpram_port_host_assertions.sv
// Pin protocol checks for the RAM port controller
`timescale 1ns/100ps
`default_nettype none
module dpram_port_host_checker (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic rsp_valid_o,
	input wire logic [9:0] ram_addr_o,
	input wire logic ram_select_n_o,
	input wire logic ram_write_n_o,
	input wire logic ram_output_en_n_o,
	input wire logic ram_busy_n_i
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	read_strobe_a: assert property (!ram_output_en_n_o |-> ram_write_n_o)
		else $error("strobe in read");
	addr_held_a: assert property (!ram_select_n_o [*2] |-> $stable(ram_addr_o))
		else $error("address moved");
	pulse_width_a: assert property ($fell(ram_write_n_o) |-> !ram_write_n_o [*3])
		else $error("short strobe");
	strobe_late_a: assert property ($fell(ram_write_n_o) |-> $past(!ram_select_n_o, 2))
		else $error("early strobe");
	busy_wait_a: assert property ($rose(ram_busy_n_i) |-> !rsp_valid_o [*3])
		else $error("no extension");
	strobe_in_sel_a: assert property (!ram_write_n_o |-> !ram_select_n_o)
		else $error("strobe outside select");
endmodule // dpram_port_host_checker
bind dpram_port_host dpram_port_host_checker checker_i (.*);
`default_nettype wire

// ### verification/dpram_model.sv
// Behavioural device on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
module dpram_model (
	input wire logic [9:0] a_i,
	input wire logic sel_n_i,
	input wire logic wr_n_i,
	input wire logic oe_n_i,
	input wire logic [7:0] d_i,
	input wire logic hold_i,
	input wire logic poke_i,
	output logic [7:0] q_o,
	output logic busy_n_o,
	output logic int_n_o
);
	logic [7:0] mem [0:1023];
	logic [7:0] last = 8'h00;
	logic int_n = 1'b1;
	logic poked = 1'b0;
	logic rd;
	logic wr;
	assign busy_n_o = !(hold_i && !sel_n_i);
	assign rd = !sel_n_i && !oe_n_i && wr_n_i;
	assign wr = !sel_n_i && !wr_n_i && busy_n_o;
	assign q_o = rd ? mem[a_i] : ~last;
	assign int_n_o = int_n;
	// Far port fills the near mailbox once; a near read clears the flag
	always @* begin
		if (poke_i && !poked) begin
			poked = 1'b1;
			mem[10'h3FE] = 8'h3C;
			int_n = 1'b0;
		end
		if (rd) last = mem[a_i];
		if (rd && a_i == 10'h3FE) int_n = 1'b1;
		if (wr) mem[a_i] = d_i;
	end
endmodule // dpram_model
`default_nettype wire

// ### verification/dpram_port_host_tb.sv
// Self-checking bench for the RAM port controller
`timescale 1ns/100ps
`default_nettype none
module dpram_port_host_tb;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [9:0] req_addr_i = 10'h000;
	logic [7:0] req_wdata_i = 8'h00;
	logic hold = 1'b0;
	logic poke = 1'b0;
	logic req_ready_o, rsp_valid_o, rsp_busy_seen_o, mail_pending_o, sel_n, wr_n, oe_n, doe_n;
	logic busy_n, int_n;
	logic [7:0] rsp_rdata_o, dout, q, bus;
	logic [9:0] addr;
	logic [7:0] ref_mem [0:1023];
	logic [9:0] exp_q [$];
	logic [9:0] e;
	int bad_count = 0;
	int num_checks = 0;
	always #5 clk_i = ~clk_i;
	assign bus = doe_n ? q : dout;
	dpram_port_host uut (.clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_addr_i,
		.req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .rsp_busy_seen_o,
		.mail_pending_o, .ram_addr_o(addr), .ram_select_n_o(sel_n), .ram_write_n_o(wr_n),
		.ram_output_en_n_o(oe_n), .ram_data_i(bus), .ram_data_o(dout),
		.ram_data_oe_n_o(doe_n), .ram_busy_n_i(busy_n), .ram_int_n_i(int_n));
	dpram_model dev (.a_i(addr), .sel_n_i(sel_n), .wr_n_i(wr_n), .oe_n_i(oe_n), .d_i(bus),
		.hold_i(hold), .poke_i(poke), .q_o(q), .busy_n_o(busy_n), .int_n_o(int_n));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] expv);
		num_checks++;
		if (seen !== expv) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, expv, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic op(input logic w, input logic [9:0] a, input logic [7:0] d, input logic b);
		int i;
		exp_q.push_back({~w, b, w ? d : ref_mem[a]});
		if (w) ref_mem[a] = d;
		req_valid_i = 1'b1;
		req_write_i = w;
		req_addr_i = a;
		req_wdata_i = d;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		for (i = 0; !req_ready_o && i < 99; i++) @(negedge clk_i);
		@(negedge clk_i);
		if (i >= 99) bad_count++;
	endtask
	always @(negedge clk_i) begin
		if (rsp_valid_o) begin
			e = exp_q.pop_front();
			chk("busy", {7'h00, rsp_busy_seen_o}, {7'h00, e[8]});
			if (e[9]) chk("data", rsp_rdata_o, e[7:0]);
		end
	end
	initial begin
		logic [9:0] a;
		void'($urandom(30062));
		repeat (6) @(negedge clk_i);
		sys_rst_i = 1'b0;
		for (int k = 0; k < 6; k++) begin
			a = 10'($urandom % 1022);
			op(1'b1, a, 8'($urandom), 1'b0);
			op(1'b0, a, 8'h00, 1'b0);
		end
		for (int w = 1; w >= 0; w--) begin
			hold = 1'b1;
			fork
				op(w[0], 10'h155, 8'hC3, 1'b1);
				begin
					repeat (12) @(negedge clk_i);
					hold = 1'b0;
				end
			join
		end
		poke = 1'b1;
		repeat (3) @(negedge clk_i);
		chk("pend", {7'h00, mail_pending_o}, 8'h01);
		ref_mem[10'h3FE] = 8'h3C;
		op(1'b0, 10'h3FE, 8'h00, 1'b0);
		chk("pend", {7'h00, mail_pending_o}, 8'h00);
		complete_run();
	end
	initial begin
		#100000;
		bad_count++;
		complete_run();
	end
endmodule // dpram_port_host_tb
`default_nettype wire
